// [verilog/qei_top.v]
/*
 quadrature encoder interface with an AXI4-Lite register slave.
 assumes encoder pins already synchronous-safe after the two-stage
 synchroniser here; one clock clk_sys, async active-low reset.
*/
// Behaviour
// - 32-bit position counts on each single-bit state change
// - up on 10-11, 00-10, 11-01, 01-00
// - down on the reverse four transitions
// - both bits changing: ignored, no direction change
// - unchanged state leaves count and direction
// - direction held until opposite step, readable
// - four inputs, counting every edge (4x)
// - programmable noise filter on every input
// - index pulse may reset position count
// - velocity, index, interval counters are read/write
// - interval timer measures, shadow captured on access
// - low compare: position at or below
// - init/capture/high compare shared register
// - timer, ext up/down, gated count, gated timer modes
// - latched event flags with enable bits
// - clear, set, invert aliases at +4, +8, +C
// - 32-bit shadow registers have no aliases
// - control bits 31:16 read zero
// - mode field selects quad/ext/gate/timer
// - swap exchanges phase A and B
// - disabled module stops, registers stay accessible
`include "qei_map.vh"
`timescale 1ns/1ps
`default_nettype none
module qei_top #(
	parameter FLT_W = 8
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        phase_a_input,
	input  wire        phase_b_input,
	input  wire        index_pulse_input,
	input  wire        home_pulse_input,
	output reg         count_compare_out,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	// registers
	reg  [31:0] ctrl_reg, ioc_reg, stat_reg;
	reg  [31:0] pos_reg, vel_reg, idx_reg, tmr_reg, tmr_shd_reg;
	reg  [31:0] cmpl_reg, icc_reg;
	reg  [31:0] ival_reg;
	reg         dir_reg;
	reg  [3:0]  sync1_reg, sync2_reg;
	wire [3:0]  filt_lvl;
	reg  [FLT_W-1:0] fdiv_reg, tdiv_reg;
	reg  [1:0]  prev_ab_reg;
	reg         idx_prev_reg, home_prev_reg, extclk_prev_reg;
	reg  [7:0]  aw_addr_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         aw_full_reg, w_full_reg;

	// field decode
	wire        en       = ctrl_reg[`QEI_CTRL_EN];
	wire [2:0]  pimod    = ctrl_reg[`QEI_CTRL_PIMOD_LO+2:`QEI_CTRL_PIMOD_LO];
	wire [2:0]  tdiv_sel = ctrl_reg[`QEI_CTRL_DIV_LO+2:`QEI_CTRL_DIV_LO];
	wire [1:0]  ccm      = ctrl_reg[`QEI_CTRL_CCM_LO+1:`QEI_CTRL_CCM_LO];
	wire [2:0]  fdiv_sel = ioc_reg[`QEI_IOC_FDIV_LO+2:`QEI_IOC_FDIV_LO];
	wire [1:0]  outfnc   = ioc_reg[`QEI_IOC_OUTF_LO+1:`QEI_IOC_OUTF_LO];

	// divided tick: 1:2^sel of clk_sys
	localparam [FLT_W-1:0] ONE_F = {{(FLT_W-1){1'b0}}, 1'b1};
	function tick_of;
		input [FLT_W-1:0] cnt;
		input [2:0]       sel;
		reg   [FLT_W-1:0] m;
		begin
			m = (ONE_F << sel) - ONE_F;
			tick_of = ((cnt & m) == m);
		end
	endfunction

	wire flt_tick = tick_of(fdiv_reg, fdiv_sel);
	wire tmr_tick = tick_of(tdiv_reg, tdiv_sel);

	// free dividers; the count stays alive even while disabled so access remains cheap
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fdiv_reg <= {FLT_W{1'b0}};
			tdiv_reg <= {FLT_W{1'b0}};
		end else begin
			fdiv_reg <= fdiv_reg + 1'b1;
			tdiv_reg <= tdiv_reg + 1'b1;
		end
	end

	// two-stage synchroniser, first stage read only by the second
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= {home_pulse_input, index_pulse_input, phase_b_input, phase_a_input};
			sync2_reg <= sync1_reg;
		end
	end

	// digital filter: take a new level after FLT_TICKS stable ticks
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_flt
			// per-input state kept local so each flop has one driver
			reg [2:0] stable_reg;
			reg       lvl_reg;
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					stable_reg <= 3'h0;
					lvl_reg    <= 1'b0;
				end else if (!ioc_reg[`QEI_IOC_FLT]) begin
					stable_reg <= 3'h0;
					lvl_reg    <= sync2_reg[gi];
				end else if (sync2_reg[gi] == lvl_reg) begin
					stable_reg <= 3'h0;
				end else if (flt_tick) begin
					if (stable_reg == `QEI_FLT_TICKS - 1) begin
						lvl_reg    <= sync2_reg[gi];
						stable_reg <= 3'h0;
					end else begin
						stable_reg <= stable_reg + 3'h1;
					end
				end
			end
			assign filt_lvl[gi] = lvl_reg;
		end
	endgenerate

	// polarity then swap; swapped pair feeds status and decoder
	wire [3:0] pol = filt_lvl ^ {ioc_reg[`QEI_IOC_HPOL], ioc_reg[`QEI_IOC_IPOL],
		ioc_reg[`QEI_IOC_BPOL], ioc_reg[`QEI_IOC_APOL]};
	wire qa = ioc_reg[`QEI_IOC_SWAP] ? pol[1] : pol[0];
	wire qb = ioc_reg[`QEI_IOC_SWAP] ? pol[0] : pol[1];
	wire [3:0] pin_stat = {pol[3], pol[2], qb, qa};

	// truth table decode, state written as {A,B}
	wire [1:0] cur_ab = {qa, qb};
	reg        step_up, step_dn;
	always @* begin
		step_up = 1'b0;
		step_dn = 1'b0;
		case ({prev_ab_reg, cur_ab})
			4'b10_11, 4'b00_10, 4'b11_01, 4'b01_00: step_up = 1'b1;
			4'b11_10, 4'b10_00, 4'b00_01, 4'b01_11: step_dn = 1'b1;
			default: ; // equal or double change: no step
		endcase
	end

	// event sources for the selected mode
	wire idx_edge  = pin_stat[2] & ~idx_prev_reg;
	wire home_edge = pin_stat[3] & ~home_prev_reg;
	wire ext_edge  = qa & ~extclk_prev_reg;
	wire gate_ok   = ~ctrl_reg[`QEI_CTRL_GATE] | qb;
	wire neg_dir   = ctrl_reg[`QEI_CTRL_POL];
	reg  cnt_step, cnt_up;
	always @* begin
		cnt_step = 1'b0;
		cnt_up   = 1'b1;
		case (ccm)
			`QEI_CCM_QUAD: begin
				cnt_step = step_up | step_dn;
				cnt_up   = step_up;
			end
			`QEI_CCM_EXT_UD: begin
				cnt_step = ext_edge;
				cnt_up   = qb ^ neg_dir;
			end
			`QEI_CCM_EXT_GATE: begin
				cnt_step = ext_edge & gate_ok;
				cnt_up   = ~neg_dir;
			end
			`QEI_CCM_TMR_GATE: begin
				cnt_step = tmr_tick & gate_ok;
				cnt_up   = ~neg_dir;
			end
			default: ;
		endcase
	end

	wire [31:0] pos_step  = cnt_up ? pos_reg + 32'h1 : pos_reg - 32'h1;
	wire        pos_ovf   = cnt_step & (cnt_up ? (pos_reg == 32'h7FFFFFFF) : (pos_reg == 32'h80000000));
	wire        vel_ovf   = cnt_step & (vel_reg == (cnt_up ? 32'h7FFFFFFF : 32'h80000000));
	wire        lo_hit    = $signed(pos_reg) <= $signed(cmpl_reg);
	wire        hi_hit    = $signed(pos_reg) >= $signed(icc_reg);
	wire        idx_init  = idx_edge & (pimod == 3'h1 || pimod == 3'h7);
	wire        idx_load  = idx_edge & (pimod == 3'h2);
	wire        cap_event = (idx_edge & ioc_reg[`QEI_IOC_QCAP]) | (home_edge & ioc_reg[`QEI_IOC_HCAP]);

	// AXI4-Lite decode; alias slot from address bits 3:2
	wire        wr_go   = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	wire [7:0]  wr_base = {aw_addr_reg[7:4], 4'h0};
	wire [1:0]  wr_alias = aw_addr_reg[3:2];
	wire [31:0] wmask   = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire        rd_go   = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;
	assign s_axi_arready = ~s_axi_rvalid;

	// aliased write: plain, clear, set, invert within byte lanes
	function [31:0] alias_wr;
		input [31:0] old;
		input [31:0] d;
		input [31:0] m;
		input [1:0]  al;
		begin
			case (al)
				`QEI_ALIAS_CLR: alias_wr = old & ~(d & m);
				`QEI_ALIAS_SET: alias_wr = old | (d & m);
				`QEI_ALIAS_INV: alias_wr = old ^ (d & m);
				default:        alias_wr = (old & ~m) | (d & m);
			endcase
		end
	endfunction

	// software writes to a counter target; shadow regs ignore alias slots
	wire sw_wr_ok   = wr_go & (wr_alias == 2'h0 || (wr_base != `QEI_OFF_POS_SHD
		&& wr_base != `QEI_OFF_VEL_SHD && wr_base != `QEI_OFF_IDX_SHD));
	wire wr_hit_pos = sw_wr_ok & (wr_base == `QEI_OFF_POS);
	wire wr_hit_vel = sw_wr_ok & (wr_base == `QEI_OFF_VEL);
	wire wr_hit_idx = sw_wr_ok & (wr_base == `QEI_OFF_IDX);
	wire wr_hit_tmr = sw_wr_ok & (wr_base == `QEI_OFF_TMR);
	wire wr_data_w  = alias_wr(32'h0, w_data_reg, wmask, wr_alias) != 32'h0;

	// bus channel capture
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg  <= 1'b0;
			w_full_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 32'h0;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid & ~aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_base > `QEI_OFF_ICC) ? 2'h2 : 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				// direction status word sits just past the map and reads okay
				s_axi_rresp  <= ({s_axi_araddr[7:4], 4'h0} > `QEI_OFF_DIR) ? 2'h2 : 2'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// read mux; alias slots read zero as they carry no meaning
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h0;
		if (s_axi_araddr[3:2] == 2'h0) begin
			case ({s_axi_araddr[7:4], 4'h0})
				`QEI_OFF_CTRL:    rd_val = ctrl_reg;
				`QEI_OFF_IOC:     rd_val = {ioc_reg[31:4], pin_stat};
				`QEI_OFF_STAT:    rd_val = stat_reg;
				`QEI_OFF_POS:     rd_val = pos_reg;
				`QEI_OFF_VEL:     rd_val = vel_reg;
				`QEI_OFF_IDX:     rd_val = idx_reg;
				`QEI_OFF_TMR:     rd_val = tmr_reg;
				`QEI_OFF_TMR_SHD: rd_val = tmr_shd_reg;
				`QEI_OFF_CMPL:    rd_val = cmpl_reg;
				`QEI_OFF_ICC:     rd_val = icc_reg;
				`QEI_OFF_DIR:     rd_val = {31'h0, dir_reg};
				default:          rd_val = 32'h0;
			endcase
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) s_axi_rdata <= 32'h0;
		else if (rd_go) s_axi_rdata <= rd_val;
	end

	// config registers written by software only
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `QEI_RST_VAL;
			ioc_reg  <= `QEI_RST_VAL;
			cmpl_reg <= `QEI_RST_VAL;
		end else if (sw_wr_ok) begin
			case (wr_base)
				`QEI_OFF_CTRL: ctrl_reg <= alias_wr(ctrl_reg, w_data_reg, wmask, wr_alias) & `QEI_CTRL_MASK;
				`QEI_OFF_IOC:  ioc_reg  <= alias_wr(ioc_reg, w_data_reg, wmask, wr_alias) & `QEI_IOC_MASK;
				`QEI_OFF_CMPL: cmpl_reg <= alias_wr(cmpl_reg, w_data_reg, wmask, wr_alias);
				default: ;
			endcase
		end
	end

	// counters; software write wins over a count in the same cycle
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pos_reg       <= `QEI_RST_VAL;
			vel_reg       <= `QEI_RST_VAL;
			idx_reg       <= `QEI_RST_VAL;
			tmr_reg       <= `QEI_RST_VAL;
			tmr_shd_reg   <= `QEI_RST_VAL;
			ival_reg      <= `QEI_RST_VAL;
			icc_reg       <= `QEI_RST_VAL;
			dir_reg       <= 1'b0;
			prev_ab_reg   <= 2'h0;
			idx_prev_reg  <= 1'b0;
			home_prev_reg <= 1'b0;
			extclk_prev_reg <= 1'b0;
		end else begin
			prev_ab_reg     <= cur_ab;
			idx_prev_reg    <= pin_stat[2];
			home_prev_reg   <= pin_stat[3];
			extclk_prev_reg <= qa;
			if (en) begin
				if (cnt_step)
					dir_reg <= cnt_up;
				if (idx_init)
					pos_reg <= 32'h0;
				else if (idx_load | (pimod == 3'h5 && cnt_step && pos_reg == icc_reg))
					pos_reg <= icc_reg;
				else if (cnt_step)
					pos_reg <= pos_step;
				if (cnt_step)
					vel_reg <= cnt_up ? vel_reg + 32'h1 : vel_reg - 32'h1;
				if (idx_edge)
					idx_reg <= dir_reg ? idx_reg + 32'h1 : idx_reg - 32'h1; // last travel direction, not idle cnt_up
				// interval: ticks since last pulse, latched at each pulse
				if (cnt_step) begin
					tmr_reg  <= ival_reg;
					ival_reg <= 32'h0;
				end else if (tmr_tick) begin
					ival_reg <= ival_reg + 32'h1;
				end
				if (cap_event)
					icc_reg <= pos_reg;
			end
			if (wr_go && (wr_base == `QEI_OFF_TMR || wr_base == `QEI_OFF_TMR_SHD))
				tmr_shd_reg <= tmr_reg;
			else if (rd_go && {s_axi_araddr[7:4], 4'h0} == `QEI_OFF_TMR)
				tmr_shd_reg <= tmr_reg;
			if (wr_hit_pos) pos_reg <= alias_wr(pos_reg, w_data_reg, wmask, wr_alias);
			if (wr_hit_vel) vel_reg <= alias_wr(vel_reg, w_data_reg, wmask, wr_alias);
			if (wr_hit_idx) idx_reg <= alias_wr(idx_reg, w_data_reg, wmask, wr_alias);
			if (wr_hit_tmr) tmr_reg <= alias_wr(tmr_reg, w_data_reg, wmask, wr_alias);
			if (sw_wr_ok && wr_base == `QEI_OFF_ICC)
				icc_reg <= alias_wr(icc_reg, w_data_reg, wmask, wr_alias);
		end
	end

	// event flags: hardware set beats software clear in the same cycle
	wire [6:0] ev = {hi_hit & cnt_step, lo_hit & cnt_step, pos_ovf, cap_event | idx_load | idx_init,
		vel_ovf, home_edge, idx_edge};
	reg  [31:0] stat_next;
	integer k;
	always @* begin
		stat_next = stat_reg;
		if (sw_wr_ok && wr_base == `QEI_OFF_STAT)
			stat_next = alias_wr(stat_reg, w_data_reg, wmask, wr_alias) & `QEI_STAT_MASK;
		for (k = 0; k < 7; k = k + 1)
			if (ev[6-k] & en)
				stat_next[13-2*k] = 1'b1;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) stat_reg <= `QEI_RST_VAL;
		else stat_reg <= stat_next;
	end

	// compare output pin
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) count_compare_out <= 1'b0;
		else count_compare_out <= en & ((outfnc[1] & lo_hit) | (outfnc[0] & hi_hit));
	end

	// spare bits of wr_data_w fold into nothing; kept for strobe check
	wire unused_ok = wr_data_w | wr_hit_pos;
endmodule // qei_top
`default_nettype wire

// [verilog/qei_map.vh]
/*
 encoder interface constants: register byte offsets, alias offsets,
 field positions and reset values. included by the design file and the bench.
*/
`ifndef QEI_MAP_VH
`define QEI_MAP_VH
// register bases, each block of four words is base, clear, set, invert
`define QEI_OFF_CTRL      8'h00
`define QEI_OFF_IOC       8'h10
`define QEI_OFF_STAT      8'h20
`define QEI_OFF_POS       8'h30
`define QEI_OFF_POS_SHD   8'h40
`define QEI_OFF_VEL       8'h50
`define QEI_OFF_VEL_SHD   8'h60
`define QEI_OFF_IDX       8'h70
`define QEI_OFF_IDX_SHD   8'h80
`define QEI_OFF_TMR       8'h90
`define QEI_OFF_TMR_SHD   8'hA0
`define QEI_OFF_CMPL      8'hB0
`define QEI_OFF_ICC       8'hC0
`define QEI_OFF_DIR       8'hD0
`define QEI_ALIAS_CLR     2'h1
`define QEI_ALIAS_SET     2'h2
`define QEI_ALIAS_INV     2'h3
// control fields
`define QEI_CTRL_MASK     32'h0000BF7F
`define QEI_CTRL_EN       15
`define QEI_CTRL_PIMOD_LO 10
`define QEI_CTRL_DIV_LO   4
`define QEI_CTRL_POL      3
`define QEI_CTRL_GATE     2
`define QEI_CTRL_CCM_LO   0
// io control fields, bits 3:0 are live pin status
`define QEI_IOC_MASK      32'h0001FFF0
`define QEI_IOC_HCAP      16
`define QEI_IOC_QCAP      15
`define QEI_IOC_OUTF_LO   9
`define QEI_IOC_FLT       14
`define QEI_IOC_FDIV_LO   11
`define QEI_IOC_SWAP      8
`define QEI_IOC_HPOL      7
`define QEI_IOC_IPOL      6
`define QEI_IOC_BPOL      5
`define QEI_IOC_APOL      4
// status: flag at odd bit, enable below it
`define QEI_STAT_MASK     32'h00003FFF
`define QEI_STAT_EN_MASK  32'h00001555
`define QEI_RST_VAL       32'h00000000
// filter: input must be stable this many divided ticks
`define QEI_FLT_TICKS     3
`define QEI_CCM_QUAD      2'h0
`define QEI_CCM_EXT_UD    2'h1
`define QEI_CCM_EXT_GATE  2'h2
`define QEI_CCM_TMR_GATE  2'h3
`endif

// [dv/qei_asserts.sv]
/*
 register-port checker for the encoder block.
 assumes it is bound to qei_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module qei_asserts (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// address and data taken together, as the bench offers them
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// responses stay put until the master takes them
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted with data pending");
	wr_resp_a: assert property (s_wr ##0 (s_axi_awaddr < 8'hD0) |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'h0))
		else $error("mapped write not answered okay");
	rd_resp_a: assert property (s_rd |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	rd_err_a: assert property (s_rd ##0 (s_axi_araddr[7:4] > 4'hD) |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	dir_ok_a: assert property (s_rd ##0 (s_axi_araddr == 8'hD0) |=> s_axi_rresp == 2'h0)
		else $error("direction status read refused");
	// alias slots and the position, velocity and index shadow words read back as zero
	alias_zero_a: assert property (s_rd ##0 (s_axi_araddr[3:2] != 2'h0 && s_axi_araddr < 8'hD0) |=> s_axi_rdata == 32'h0)
		else $error("alias read not zero");
	shadow_zero_a: assert property (s_rd ##0 (s_axi_araddr inside {8'h40, 8'h60, 8'h80}) |=> s_axi_rdata == 32'h0)
		else $error("shadow read not zero");
	ctrl_hi_a: assert property (s_rd ##0 (s_axi_araddr == 8'h00) |=> s_axi_rdata[31:16] == 16'h0)
		else $error("control upper half not zero");
endmodule // qei_asserts
`default_nettype wire

// [dv/qei_enc_model.sv]
/*
 incremental encoder model: two phases, index and home.
 assumes the bench calls its tasks just after a rising clk_sys edge.
*/
`timescale 1ns/1ps
`default_nettype none
module qei_enc_model (
	input  wire logic clk_sys,
	output var logic  phase_a,
	output var logic  phase_b,
	output var logic  index_pulse,
	output var logic  home_pulse
);
	initial begin
		phase_a = 1'b0;
		phase_b = 1'b0;
		index_pulse = 1'b0;
		home_pulse = 1'b0;
	end
	// one phase moves per step; dwell covers sync, filter and count latency
	task automatic step(input bit up);
		@(posedge clk_sys);
		if ((phase_a == phase_b) == up) phase_a <= ~phase_a;
		else phase_b <= ~phase_b;
		repeat (10) @(posedge clk_sys);
	endtask
	// both phases at once: only on the bench's explicit request
	task automatic jump;
		@(posedge clk_sys);
		phase_a <= ~phase_a;
		phase_b <= ~phase_b;
		repeat (10) @(posedge clk_sys);
	endtask
	// one-cycle spike on phase a, too short to pass a filter
	task automatic glitch;
		@(posedge clk_sys);
		phase_a <= ~phase_a;
		@(posedge clk_sys);
		phase_a <= ~phase_a;
		repeat (10) @(posedge clk_sys);
	endtask
	task automatic index_pulse_once;
		@(posedge clk_sys);
		index_pulse <= 1'b1;
		repeat (4) @(posedge clk_sys);
		index_pulse <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
	// home marker, wide enough to pass a 1:1 filter
	task automatic home_pulse_once;
		@(posedge clk_sys);
		home_pulse <= 1'b1;
		repeat (4) @(posedge clk_sys);
		home_pulse <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
endmodule // qei_enc_model
`default_nettype wire

// [dv/tb_top.sv]
/*
 register-level bench for the encoder block with an encoder model.
 assumes the map header is on the include path; filter starts bypassed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "qei_map.vh"
module tb_top;
	localparam logic [7:0] DIR_ADDR = `QEI_OFF_DIR;
	logic        clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, cmp, pa, pb, pi, ph;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [3:0]  wstrb;
	int          err_total, compares;
	qei_top i_qei_top (.clk_sys(clk_sys), .rst_n(rst_n), .phase_a_input(pa), .phase_b_input(pb),
		.index_pulse_input(pi), .home_pulse_input(ph), .count_compare_out(cmp),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	qei_enc_model i_qei_enc_model (.clk_sys(clk_sys), .phase_a(pa), .phase_b(pb), .index_pulse(pi), .home_pulse(ph));
	always #50 clk_sys = ~clk_sys;
	// offer address and data together, release each as it is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (aw || w) begin
			@(posedge clk_sys);
			if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
			if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
		end
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		rd(a);
		chk(d & m, e);
	endtask
	task automatic tdone(input string s);
		$display("test %s finished", s);
	endtask
	task automatic complete_run;
		$display("compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		#1000000;
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run();
	end
	// main sequence
	initial begin
		clk_sys = 1'b0; rst_n = 1'b0; err_total = 0; compares = 0;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rc(`QEI_OFF_CTRL, 32'h0);
		wr(`QEI_OFF_CTRL, 32'hFFFFFFFF);
		chk({30'h0, r}, 32'h0);
		rc(`QEI_OFF_CTRL, 32'h0000BF7F);
		wr(`QEI_OFF_CTRL, 32'h00008000);
		rd(8'hE0);
		chk({30'h0, r}, 32'h2);
		wr(8'hE0, 32'h00000001);
		chk({30'h0, r}, 32'h2);
		tdone("registers");
		// clear, set, invert slots on the low compare word
		wr(`QEI_OFF_CMPL, 32'h0000F0F0);
		wr(`QEI_OFF_CMPL + 8'h4, 32'h000000F0);
		rc(`QEI_OFF_CMPL, 32'h0000F000);
		wr(`QEI_OFF_CMPL + 8'h8, 32'h0000000F);
		rc(`QEI_OFF_CMPL, 32'h0000F00F);
		wr(`QEI_OFF_CMPL + 8'hC, 32'h0000FFFF);
		rc(`QEI_OFF_CMPL, 32'h00000FF0);
		rc(`QEI_OFF_CMPL + 8'h4, 32'h0);
		// only byte lane 0 enabled
		wr(`QEI_OFF_CMPL, 32'hAAAA5555, 4'h1);
		rc(`QEI_OFF_CMPL, 32'h00000F55);
		wr(`QEI_OFF_POS_SHD, 32'h00001234);
		rc(`QEI_OFF_POS_SHD, 32'h0);
		wr(`QEI_OFF_IDX, 32'h00000055);
		rc(`QEI_OFF_IDX, 32'h00000055);
		wr(`QEI_OFF_VEL, 32'h00000007);
		rc(`QEI_OFF_VEL, 32'h00000007);
		tdone("aliases");
		// count up across the 32-bit wrap
		wr(`QEI_OFF_POS, 32'hFFFFFFFE);
		repeat (4) i_qei_enc_model.step(1'b1);
		rc(`QEI_OFF_POS, 32'h00000002);
		rc(DIR_ADDR, 32'h1, 32'h1);
		repeat (5) i_qei_enc_model.step(1'b0);
		rc(`QEI_OFF_POS, 32'hFFFFFFFD);
		rc(DIR_ADDR, 32'h0, 32'h1);
		tdone("count");
		// double change is ignored, the next good step counts
		i_qei_enc_model.jump();
		rc(`QEI_OFF_POS, 32'hFFFFFFFD);
		rc(DIR_ADDR, 32'h0, 32'h1);
		i_qei_enc_model.step(1'b1);
		rc(`QEI_OFF_POS, 32'hFFFFFFFE);
		rc(DIR_ADDR, 32'h1, 32'h1);
		tdone("invalid");
		// swap only while both phases agree, so no false step
		wr(`QEI_OFF_IOC + 8'h8, 32'h00000100);
		repeat (2) i_qei_enc_model.step(1'b1);
		rc(`QEI_OFF_POS, 32'hFFFFFFFC);
		wr(`QEI_OFF_IOC + 8'h4, 32'h00000100);
		tdone("swap");
		// disabled: movement ignored, registers still writable
		wr(`QEI_OFF_CTRL + 8'h4, 32'h00008000);
		i_qei_enc_model.step(1'b1);
		rc(`QEI_OFF_POS, 32'hFFFFFFFC);
		i_qei_enc_model.step(1'b0);
		wr(`QEI_OFF_POS, 32'h00000010);
		rc(`QEI_OFF_POS, 32'h00000010);
		wr(`QEI_OFF_CTRL + 8'h8, 32'h00008000);
		tdone("disable");
		// every index resets position and latches its flag
		wr(`QEI_OFF_CTRL + 8'h8, 32'h00000400);
		i_qei_enc_model.index_pulse_once();
		rc(`QEI_OFF_POS, 32'h0);
		rc(`QEI_OFF_STAT, 32'h2, 32'h2);
		wr(`QEI_OFF_STAT + 8'h4, 32'h00000002);
		rc(`QEI_OFF_STAT, 32'h0, 32'h2);
		wr(`QEI_OFF_CTRL + 8'h4, 32'h00001C00);
		tdone("index");
		// filter on: a one-cycle spike must not count
		wr(`QEI_OFF_IOC + 8'h8, 32'h00004000);
		i_qei_enc_model.glitch();
		rc(`QEI_OFF_POS, 32'h0);
		i_qei_enc_model.step(1'b1);
		rc(`QEI_OFF_POS, 32'h1);
		// shadow must hold what the timer read returned
		rd(`QEI_OFF_TMR);
		rc(`QEI_OFF_TMR_SHD, d);
		tdone("filter");
		// home edge captures position into the shared register
		wr(`QEI_OFF_IOC + 8'h8, 32'h00010000);
		i_qei_enc_model.home_pulse_once();
		rc(`QEI_OFF_ICC, 32'h1);
		rc(`QEI_OFF_STAT, 32'h8, 32'h8);
		tdone("home");
		// external clock on rising A, B low counts down
		wr(`QEI_OFF_CTRL + 8'h8, 32'h00000001);
		repeat (4) i_qei_enc_model.step(1'b1);
		rc(`QEI_OFF_POS, 32'h0);
		wr(`QEI_OFF_CTRL + 8'h4, 32'h00000001);
		tdone("external");
		// low-side compare, signed
		wr(`QEI_OFF_CMPL, 32'h00000005);
		wr(`QEI_OFF_IOC + 8'h8, 32'h00000400);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, cmp}, 32'h1);
		wr(`QEI_OFF_CMPL, 32'hFFFFFFFF);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, cmp}, 32'h0);
		tdone("compare");
		complete_run();
	end
endmodule // tb_top
bind qei_top qei_asserts i_qei_asserts (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
